// ===== verilog/dcf_pkg.sv
// Shared constants and carrier types for the dual-clock FIFO flags block
package dcf_pkg;
  localparam int          DATA_W       = 18;
  localparam int          ADDR_W       = 13;
  localparam int          BUS_AW       = 8;
  localparam logic [15:0] OFS_SER_DEF  = 16'h03ff;
  localparam logic [15:0] OFS_PAR_DEF  = 16'h007f;
  // Register byte addresses
  localparam logic [7:0]  REG_EMPTY_OFS = 8'h00;
  localparam logic [7:0]  REG_FULL_OFS  = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [7:0]  REG_LEVEL     = 8'h0c;
  // Status register fields, then bus response codes
  localparam int          ST_FALL      = 0;
  localparam int          ST_SERIAL    = 1;
  localparam int          ST_READY     = 2;
  localparam int          ST_EMPTY_PIN = 8;
  localparam int          ST_FULL_PIN  = 9;
  localparam int          ST_AE        = 10;
  localparam int          ST_HF        = 11;
  localparam int          ST_AF        = 12;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;
  typedef struct packed {
    logic fallThrough;
    logic serialLoad;
  } dcf_cfg_t;
endpackage

// ===== verilog/dcf_fifo.sv
// Deep FIFO with standard / fall-through flags, offsets and register slave
`timescale 1ns/1ns
`default_nettype none
module dcf_fifo #(
  parameter int DW = dcf_pkg::DATA_W,
  parameter int AW = dcf_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // Straps and serial load
  input  wire logic                       timing_select_serial_in,
  input  wire logic                       load_select_n,
  input  wire logic                       serialEnable_n,
  // Write port
  input  wire logic                       writeEnable_n,
  input  wire logic [DW-1:0]              writeData,
  // Read port
  input  wire logic                       readEnable_n,
  output logic      [DW-1:0]              data_out,
  // Flags
  output logic                            empty_indicator_n,
  output logic                            full_indicator_n,
  output logic                            almost_empty_n,
  output logic                            half_level_n,
  output logic                            almost_full_n,
  // Register bus
  input  wire logic [dcf_pkg::BUS_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [dcf_pkg::BUS_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  // Two spare pointer bits: fall-through holds depth plus one words
  localparam int            PW    = AW + 2;
  localparam int            OW    = AW;
  localparam logic [PW-1:0] DEPTH = PW'(2 ** AW);
  localparam logic [PW-1:0] HALF  = PW'(2 ** (AW - 1));

  typedef struct packed {
    dcf_pkg::dcf_cfg_t             cfg;
    logic                          cfgDone;
    logic [OW-1:0]                 emptyOfs;
    logic [OW-1:0]                 fullOfs;
    logic [PW-1:0]                 wrPtr;
    logic [PW-1:0]                 rdPtr;
    logic                          holdValid;
    logic [PW-1:0]                 wrSync1;
    logic [PW-1:0]                 wrSync2;
    logic [PW-1:0]                 consSync1;
    logic [PW-1:0]                 consSync2;
    logic [2:0]                    emptyPipe;
    logic [1:0]                    fullPipe;
    logic                          aeFlag;
    logic                          hfFlag;
    logic                          afFlag;
    logic [DW-1:0]                 dataOut;
    logic                          awReady;
    logic                          awHeld;
    logic [dcf_pkg::BUS_AW-1:0]    awAddr;
    logic                          wReady;
    logic                          wHeld;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    logic                          bValid;
    logic [1:0]                    bResp;
    logic                          arReady;
    logic                          rValid;
    logic [31:0]                   rData;
    logic [1:0]                    rResp;
  } dcf_state_t;

  dcf_state_t    st;
  dcf_state_t    nx;
  logic [DW-1:0] mem [0:(2**AW)-1];
  logic [PW-1:0] memCount;
  logic [PW-1:0] rCount;
  logic [PW-1:0] wCount;
  logic [PW-1:0] extra;
  logic          wFull;
  logic          wrAccept;
  logic          emptyRaw;
  logic          fullRaw;

  function automatic logic [OW-1:0] mergeOfs(input logic [OW-1:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
    logic [15:0] w;
    w = 16'(old);
    if (be[0])
    begin
      w[7:0] = d[7:0];
    end
    if (be[1])
    begin
      w[15:8] = d[15:8];
    end
    return w[OW-1:0];
  endfunction

  always_comb
  begin
    extra    = PW'(st.cfg.fallThrough);
    memCount = st.wrSync2 - st.rdPtr;
    rCount   = memCount + (st.cfg.fallThrough ? PW'(st.holdValid) : '0);
    wCount   = st.wrPtr - st.consSync2;
    wFull    = wCount >= DEPTH + extra;
    wrAccept = st.cfgDone && !writeEnable_n && !wFull;
    emptyRaw = st.cfg.fallThrough ? !st.holdValid : (memCount != '0);
    fullRaw  = st.cfg.fallThrough ? wFull : !wFull;
  end

  always_ff @(posedge mclk)
  begin
    if (wrAccept)
    begin
      mem[st.wrPtr[AW-1:0]] <= writeData;
    end
  end

  always_comb
  begin
    nx = st;
    // Straps are taken on the first edge after release, never by the reset itself
    if (!st.cfgDone)
    begin
      nx.cfgDone         = 1'b1;
      nx.cfg.fallThrough = timing_select_serial_in;
      nx.cfg.serialLoad  = load_select_n;
      nx.emptyOfs = load_select_n ? dcf_pkg::OFS_SER_DEF[OW-1:0]
                                  : dcf_pkg::OFS_PAR_DEF[OW-1:0];
      nx.fullOfs  = load_select_n ? dcf_pkg::OFS_SER_DEF[OW-1:0]
                                  : dcf_pkg::OFS_PAR_DEF[OW-1:0];
    end
    else
    begin
      if (st.cfg.serialLoad && !load_select_n && !serialEnable_n)
      begin
        {nx.fullOfs, nx.emptyOfs} = {timing_select_serial_in, st.fullOfs, st.emptyOfs[OW-1:1]};
      end
    end
    if (wrAccept)
    begin
      nx.wrPtr = st.wrPtr + PW'(1);
    end
    if (!st.cfg.fallThrough)
    begin
      // Strobe on an empty buffer is dropped
      if (!readEnable_n && memCount != '0)
      begin
        nx.dataOut = mem[st.rdPtr[AW-1:0]];
        nx.rdPtr   = st.rdPtr + PW'(1);
      end
    end
    else
    begin
      if (st.holdValid && !readEnable_n)
      begin
        nx.holdValid = 1'b0;
      end
      if (!nx.holdValid && memCount != '0 && st.cfgDone)
      begin
        nx.dataOut   = mem[st.rdPtr[AW-1:0]];
        nx.rdPtr     = st.rdPtr + PW'(1);
        nx.holdValid = 1'b1;
      end
    end
    // Two stages each way; consumed pointer excludes the word held in the output register in fall-through mode
    nx.wrSync1   = st.wrPtr;
    nx.wrSync2   = st.wrSync1;
    nx.consSync1 = st.rdPtr - PW'(st.holdValid);
    nx.consSync2 = st.consSync1;
    // Last stage skips one in standard mode: two stages there, three otherwise
    nx.emptyPipe[0] = st.cfgDone ? emptyRaw : 1'b0;
    nx.emptyPipe[1] = st.emptyPipe[0];
    nx.emptyPipe[2] = st.cfg.fallThrough ? st.emptyPipe[1] : st.emptyPipe[0];
    nx.fullPipe[0]  = st.cfgDone ? fullRaw : 1'b1;
    nx.fullPipe[1]  = st.fullPipe[0];
    if (st.cfgDone)
    begin
      nx.aeFlag = rCount > PW'(st.emptyOfs) + extra;
      nx.hfFlag = !(wCount >= HALF + PW'(1) + extra);
      nx.afFlag = !(wCount >= DEPTH - PW'(st.fullOfs) + extra);
    end
    // Register bus write channel
    if (s_axi_awvalid && st.awReady)
    begin
      nx.awHeld = 1'b1;
      nx.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wReady)
    begin
      nx.wHeld = 1'b1;
      nx.wData = s_axi_wdata;
      nx.wStrb = s_axi_wstrb;
    end
    if (st.bValid && s_axi_bready)
    begin
      nx.bValid = 1'b0;
    end
    if (st.awHeld && st.wHeld && !st.bValid)
    begin
      nx.awHeld = 1'b0;
      nx.wHeld  = 1'b0;
      nx.bValid = 1'b1;
      nx.bResp  = dcf_pkg::RESP_OKAY;
      unique case (st.awAddr)
        dcf_pkg::REG_EMPTY_OFS: nx.emptyOfs = mergeOfs(nx.emptyOfs, st.wData, st.wStrb);
        dcf_pkg::REG_FULL_OFS:  nx.fullOfs  = mergeOfs(nx.fullOfs, st.wData, st.wStrb);
        dcf_pkg::REG_STATUS, dcf_pkg::REG_LEVEL: nx.bResp = dcf_pkg::RESP_OKAY;
        default: nx.bResp = dcf_pkg::RESP_DECERR;
      endcase
    end
    nx.awReady = !nx.awHeld;
    nx.wReady  = !nx.wHeld;
    // Register bus read channel: the only path that returns offsets
    if (st.rValid && s_axi_rready)
    begin
      nx.rValid  = 1'b0;
      nx.arReady = 1'b1;
    end
    if (s_axi_arvalid && st.arReady)
    begin
      nx.arReady = 1'b0;
      nx.rValid  = 1'b1;
      nx.rResp   = dcf_pkg::RESP_OKAY;
      nx.rData   = '0;
      unique case (s_axi_araddr)
        dcf_pkg::REG_EMPTY_OFS: nx.rData = 32'(st.emptyOfs);
        dcf_pkg::REG_FULL_OFS:  nx.rData = 32'(st.fullOfs);
        dcf_pkg::REG_STATUS:
        begin
          nx.rData[dcf_pkg::ST_FALL]      = st.cfg.fallThrough;
          nx.rData[dcf_pkg::ST_SERIAL]    = st.cfg.serialLoad;
          nx.rData[dcf_pkg::ST_READY]     = st.cfgDone;
          nx.rData[dcf_pkg::ST_EMPTY_PIN] = st.emptyPipe[2];
          nx.rData[dcf_pkg::ST_FULL_PIN]  = st.fullPipe[1];
          nx.rData[dcf_pkg::ST_AE]        = st.aeFlag;
          nx.rData[dcf_pkg::ST_HF]        = st.hfFlag;
          nx.rData[dcf_pkg::ST_AF]        = st.afFlag;
        end
        dcf_pkg::REG_LEVEL: nx.rData = 32'(wCount);
        default: nx.rResp = dcf_pkg::RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st          <= '0;
      st.fullPipe <= 2'h3;
      st.hfFlag   <= 1'b1;
      st.afFlag   <= 1'b1;
      st.awReady  <= 1'b1;
      st.wReady   <= 1'b1;
      st.arReady  <= 1'b1;
    end
    else
    begin
      st <= nx;
    end
  end

  always_comb
  begin
    data_out          = st.dataOut;
    empty_indicator_n = st.emptyPipe[2];
    full_indicator_n  = st.fullPipe[1];
    almost_empty_n    = st.aeFlag;
    half_level_n      = st.hfFlag;
    almost_full_n     = st.afFlag;
    s_axi_awready     = st.awReady;
    s_axi_wready      = st.wReady;
    s_axi_bvalid      = st.bValid;
    s_axi_bresp       = st.bResp;
    s_axi_arready     = st.arReady;
    s_axi_rvalid      = st.rValid;
    s_axi_rdata       = st.rData;
    s_axi_rresp       = st.rResp;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  mode_latch_a: assert property (
    $rose(st.cfgDone) |-> st.cfg.fallThrough == $past(timing_select_serial_in))
    else $error("timing mode not taken from strap");
  std_strobe_a: assert property (
    (!st.cfg.fallThrough && readEnable_n) |=> $stable(st.rdPtr))
    else $error("standard read without strobe");
  fall_load_a: assert property (
    (st.cfg.fallThrough && st.cfgDone && !st.holdValid && memCount != '0) |=> st.holdValid)
    else $error("first word did not fall through");
  write_take_a: assert property (
    wrAccept |=> st.wrPtr == $past(st.wrPtr) + PW'(1))
    else $error("write not stored");
  std_empty_a: assert property (
    (!st.cfg.fallThrough && st.cfgDone && $past(st.cfgDone, 3))
      |-> empty_indicator_n == $past(emptyRaw, 2))
    else $error("standard empty flag stage count wrong");
  ready_stage_a: assert property (
    (st.cfg.fallThrough && st.cfgDone && $past(st.cfgDone, 4))
      |-> empty_indicator_n == $past(emptyRaw, 3))
    else $error("valid flag stage count wrong");
  full_stage_a: assert property (
    (st.cfgDone && $past(st.cfgDone, 3)) |-> full_indicator_n == $past(fullRaw, 2))
    else $error("full flag stage count wrong");
  full_block_a: assert property (
    wFull |=> $stable(st.wrPtr))
    else $error("write taken while full");
  empty_ignore_a: assert property (
    (memCount == '0 && !st.holdValid) |=> $stable(st.rdPtr) && !st.holdValid)
    else $error("read taken while empty");
  ae_level_a: assert property (
    st.cfgDone |=> almost_empty_n == ($past(rCount) > PW'($past(st.emptyOfs)) + $past(extra)))
    else $error("almost empty threshold wrong");
  af_level_a: assert property (
    st.cfgDone |=> almost_full_n == !($past(wCount) >= DEPTH - PW'($past(st.fullOfs)) + $past(extra)))
    else $error("almost full threshold wrong");
  ofs_default_a: assert property (
    $rose(st.cfgDone) |-> st.emptyOfs == (st.cfg.serialLoad ? dcf_pkg::OFS_SER_DEF[OW-1:0]
                                                           : dcf_pkg::OFS_PAR_DEF[OW-1:0]))
    else $error("offset default wrong");
  fall_latency_a: assert property (
    (st.cfg.fallThrough && wrAccept && wCount == '0) |=> !st.holdValid ##1 !st.holdValid ##1 !st.holdValid ##1 st.holdValid)
    else $error("first word latency not three edges");
  half_level_a: assert property (
    st.cfgDone |=> half_level_n == ($past(wCount) <= HALF + $past(extra)))
    else $error("half level threshold wrong");

  fill_full_c: cover property (wFull);
  fall_first_c: cover property (st.cfg.fallThrough && $rose(st.holdValid));
  bus_write_c: cover property (s_axi_bvalid && s_axi_bready);
  serial_shift_c: cover property (st.cfg.serialLoad && !load_select_n && !serialEnable_n);
  ignored_read_c: cover property (!readEnable_n && memCount == '0 && !st.holdValid);
endmodule
`default_nettype wire

// ===== test/dcf_peer.sv
// Writer and reader logic that faces the FIFO data ports
`timescale 1ns/1ns
`default_nettype none
module dcf_peer (
  // Clock
  input  wire logic                       mclk,
  // Requests from the bench
  input  wire logic                       wrReq,
  input  wire logic                       rdReq,
  input  wire logic [dcf_pkg::DATA_W-1:0] wrWord,
  // FIFO side
  output var  logic                       writeEnable_n,
  output var  logic                       readEnable_n,
  output var  logic [dcf_pkg::DATA_W-1:0] writeData
);
  initial
  begin
    writeEnable_n = 1'b1;
    readEnable_n  = 1'b1;
    writeData     = '0;
  end
  always @(posedge mclk)
  begin
    writeEnable_n <= !wrReq;
    readEnable_n  <= !rdReq;
    // Idle bus toggles so a stray capture shows up as bad data
    writeData     <= wrReq ? wrWord : ~writeData;
  end
endmodule
`default_nettype wire

// ===== test/tb_dual_clock_fifo_flags.sv
// Self-checking bench for the dual-clock FIFO flags block
`timescale 1ns/1ns
`default_nettype none
module tb_dual_clock_fifo_flags;
  // Small depth keeps fill and drain short
  localparam int AWT = 4;
  localparam int D   = 1 << AWT;
  logic        mclk, reset_n, timing_select_serial_in, load_select_n;
  logic        serialEnable_n, writeEnable_n, readEnable_n, wrReq, rdReq;
  logic        empty_indicator_n, full_indicator_n, almost_empty_n;
  logic        half_level_n, almost_full_n, ft;
  logic [17:0] wrWord, writeData, data_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          errTotal, nTests, n, m;
  logic [17:0] q[$];

  dcf_fifo #(.AW(AWT)) i_dcf_fifo (
    .mclk(mclk), .reset_n(reset_n), .timing_select_serial_in(timing_select_serial_in),
    .load_select_n(load_select_n), .serialEnable_n(serialEnable_n),
    .writeEnable_n(writeEnable_n), .writeData(writeData), .readEnable_n(readEnable_n),
    .data_out(data_out), .empty_indicator_n(empty_indicator_n), .full_indicator_n(full_indicator_n),
    .almost_empty_n(almost_empty_n), .half_level_n(half_level_n), .almost_full_n(almost_full_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  dcf_peer i_dcf_peer (.mclk(mclk), .wrReq(wrReq), .rdReq(rdReq), .wrWord(wrWord),
    .writeEnable_n(writeEnable_n), .readEnable_n(readEnable_n), .writeData(writeData));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chkW(input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      errTotal++;
      $display("unexpected word at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chkF(input logic [4:0] e);
    logic [4:0] g;
    g = {empty_indicator_n, full_indicator_n, almost_empty_n, half_level_n, almost_full_n};
    nTests++;
    if (g !== e)
    begin
      errTotal++;
      $display("unexpected flags at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  function automatic logic [4:0] expF(input int k);
    if (ft)
      return {k == 0, k > D, k > n + 1, k < D / 2 + 2, k < D + 1 - m};
    return {k > 0, k < D, k > n, k < D / 2 + 1, k < D - m};
  endfunction

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic op(input logic wr, output logic [17:0] w);
    w = 18'($urandom);
    @(posedge mclk);
    wrReq  <= wr;
    rdReq  <= !wr;
    wrWord <= w;
    @(posedge mclk);
    wrReq <= 1'b0;
    rdReq <= 1'b0;
    // Flags pass two or three stages each way before they settle
    repeat (12) @(posedge mclk);
  endtask

  task automatic shiftOfs;
    logic [2*AWT-1:0] v;
    // Offset registers are address-wide: one bit per register bit, empty LSB first
    v = {AWT'(m), AWT'(n)};
    @(posedge mclk);
    load_select_n  <= 1'b0;
    serialEnable_n <= 1'b0;
    for (int i = 0; i < 2 * AWT; i++)
    begin
      timing_select_serial_in <= v[i];
      @(posedge mclk);
    end
    load_select_n  <= 1'b1;
    serialEnable_n <= 1'b1;
  endtask

  initial
  begin
    #80000;
    errTotal++;
    $display("watchdog expired at %0t", $time);
    summarize();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [17:0] w, e;
    logic [31:0] ofsDef;
    int          cap;
    {reset_n, timing_select_serial_in, wrReq, rdReq, wrWord} = '0;
    {load_select_n, serialEnable_n} = 2'b11;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    void'($urandom(30));
    for (int md = 0; md < 2; md++)
    begin
      ft = md[0];
      n = $urandom_range(3, 1);
      m = $urandom_range(3, 1);
      // Default arrives cut to the offset register width
      ofsDef = 32'((ft ? dcf_pkg::OFS_SER_DEF : dcf_pkg::OFS_PAR_DEF) & 16'((1 << AWT) - 1));
      e = '0;
      q.delete();
      // Straps held through the first edge after release
      timing_select_serial_in <= ft;
      load_select_n <= ft;
      reset_n <= 1'b0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      timing_select_serial_in <= 1'b0;
      repeat (6) @(posedge mclk);
      axiRd(dcf_pkg::REG_STATUS, d, r);
      chkW({29'h0, 1'b1, ft, ft}, d & 32'h7);
      for (int i = 0; i < 2; i++)
      begin
        axiRd(8'(4 * i), d, r);
        chkW(ofsDef, d);
      end
      if (ft)
        shiftOfs();
      else
      begin
        axiWr(dcf_pkg::REG_EMPTY_OFS, 32'(n), r);
        chkW(32'(dcf_pkg::RESP_OKAY), 32'(r));
        axiWr(dcf_pkg::REG_FULL_OFS, 32'(m), r);
        chkW(32'(dcf_pkg::RESP_OKAY), 32'(r));
      end
      for (int i = 0; i < 2; i++)
      begin
        axiRd(8'(4 * i), d, r);
        chkW(32'(i ? m : n), d);
      end
      chkF(expF(0));
      cap = ft ? D + 1 : D;
      // One write past capacity must be dropped
      for (int k = 0; k <= cap; k++)
      begin
        op(1'b1, w);
        if (k < cap) q.push_back(w);
        if (ft)
          chkF(expF(q.size()));
        else
          chkF(expF(q.size()));
      end
      // One read past empty must be ignored
      for (int k = 0; k <= cap; k++)
      begin
        if (ft && q.size() > 0) chkW(32'(q[0]), 32'(data_out));
        op(1'b0, w);
        if (q.size() > 0) e = q.pop_front();
        if (!ft) chkW(32'(e), 32'(data_out));
        if (ft)
          chkF(expF(q.size()));
        else
          chkF(expF(q.size()));
      end
      axiWr(dcf_pkg::REG_STATUS, 32'h0, r);
      chkW(32'(dcf_pkg::RESP_OKAY), 32'(r));
      axiRd(8'h40, d, r);
      chkW(32'(dcf_pkg::RESP_DECERR), 32'(r));
      chkW(32'h0, d);
      $display("test mode %0d done", md);
    end
    summarize();
  end
endmodule
`default_nettype wire
